// ### hdl/cac_pkg.sv
// constants for the counter array control flag block
//
// Contract
// RULE1: the shared counter counts only while the run control bit is 1 and holds while it is 0.
// RULE2: a module 0, 1 or 2 match flag is set when that module reports a match or capture.
// RULE3: a set module match flag with its interrupt enabled requests the counter array interrupt.
// RULE4: a module match flag is never cleared by hardware, only by a software write of zero.
// RULE5: the overflow flag stays set until software clears it, also across interrupt entry.
// RULE6: the overflow flag is set on a 16-bit counter wrap, requests the interrupt when enabled, and resets to zero.
// RULE7: while the watchdog function is enabled, run control writes are ignored and the counter runs.
// RULE8: while the watchdog function is enabled but software has not set run control, it reads as zero.
// RULE9: while the watchdog function is enabled, writing 1 to the module 2 flag forces a watchdog reset.
package cac_pkg;
  localparam logic [7:0]  CTRL_ADDR        = 8'hD8;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam int          OVF_BIT          = 7;
  localparam int          RUN_BIT          = 6;
  localparam int          MOD2_BIT         = 2;
  localparam int          NUM_MODULES      = 3;
  localparam int          COUNT_WIDTH      = 16;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
endpackage : cac_pkg

// ### hdl/cac_counter_if.sv
// signals between the control flag logic and the shared counter
`timescale 1ns/1ps
interface cac_counter_if;
  logic        run;
  logic        tick;
  logic        wrap;
  logic [15:0] count;
  modport ctrl (output run, output tick, input wrap, input count);
  modport core (input run, input tick, output wrap, output count);
endinterface : cac_counter_if

// ### hdl/cac_counter_core.sv
// shared 16-bit counter/timer of the counter array
`timescale 1ns/1ps
module cac_counter_core
  import cac_pkg::*;
(
  input  wire logic   i_ref_clk,
  input  wire logic   i_rst_n,
  cac_counter_if.core bus
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic        wrap;
  logic        next_wrap;

  // count on each time base tick while running
  always_comb begin
    next_count = count;
    next_wrap  = 1'h0;
    if (bus.run && bus.tick) begin // RULE1
      next_count = count + 16'h0001;
      next_wrap  = (count == COUNT_MAX); // RULE6
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= COUNT_RESET;
      wrap  <= 1'h0;
    end else begin
      count <= next_count;
      wrap  <= next_wrap;
    end
  end

  assign bus.count = count;
  assign bus.wrap  = wrap;
endmodule : cac_counter_core

// ### hdl/cac_control.sv
// counter array control register with run control and sticky event flags
`timescale 1ns/1ps
module cac_control
  import cac_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  input  wire logic        i_count_tick,
  input  wire logic [2:0]  i_module_event,
  input  wire logic [2:0]  i_module_int_enable,
  input  wire logic        i_overflow_int_enable,
  input  wire logic        i_watchdog_enable,
  output logic             o_counter_running,
  output logic      [15:0] o_count,
  output logic             o_irq,
  output logic             o_watchdog_force_reset
);
  // reset release through two flops; assertion stays asynchronous so the
  // flags clear at once, even while the clock is stopped
  // the counter and the flags leave reset on one edge, so no wrap is half seen
  logic rst_meta;
  logic next_rst_meta;
  logic rst_n;
  logic next_rst_n;

  // a constant one walks in; only the second stage feeds the logic
  always_comb begin
    next_rst_meta = 1'h1;
    next_rst_n    = rst_meta;
  end

  // both stages clear together on the asynchronous edge
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_meta <= next_rst_meta;
      rst_n    <= next_rst_n;
    end
  end

  // register select, decoded for both read and write
  // one function keeps the read and write paths on the same address
  function automatic logic hit(input logic [7:0] addr);
    hit = (addr == CTRL_ADDR);
  endfunction : hit

  // decoded strobes
  logic wr_ctrl;
  logic rd_ctrl;

  // strobes for this register only; any other address has no effect
  assign wr_ctrl = i_sfr_wr && hit(i_sfr_addr);
  assign rd_ctrl = i_sfr_rd && hit(i_sfr_addr);

  // register state and its next values
  logic       run_sw;
  logic       next_run_sw;
  logic       ovf_flag;
  logic       next_ovf_flag;
  logic [2:0] mod_flag;
  logic       force_rst;
  logic       next_force_rst;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] ctrl_view;
  logic       ovf_request;
  logic [2:0] mod_request;

  // shared counter; it leaves reset on the same released copy as the flags
  cac_counter_if ctr ();

  cac_counter_core u_core (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .bus       (ctr.core)
  );

  // watchdog keeps the counter running regardless of the run bit
  // the tick comes from a divider outside, one pulse per count
  assign ctr.run  = run_sw || i_watchdog_enable; // RULE1 RULE7
  assign ctr.tick = i_count_tick;

  // per-module match flags, one sticky bit each; a hardware set beats a
  // same-cycle software clear, so no match is ever lost
  // software may also write a one, which sets the flag like an event
  genvar m;
  generate
    for (m = 0; m < NUM_MODULES; m++) begin : g_mod
      logic flag;
      logic next_flag;

      // a write loads the bit first, then an event overrides it
      always_comb begin
        next_flag = flag;
        if (wr_ctrl) begin
          next_flag = i_sfr_wdata[m]; // RULE4
        end
        if (i_module_event[m]) begin
          next_flag = 1'h1; // RULE2
        end
      end

      // flag register of this module
      always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          flag <= CTRL_RESET[m];
        end else begin
          flag <= next_flag;
        end
      end

      // gather the per-module bits for the read view and the request
      assign mod_flag[m] = flag;
    end
  endgenerate

  // overflow flag: set one cycle after the registered wrap, cleared only by
  // software; interrupt entry leaves it alone
  // a same-cycle clear loses to the wrap, as for the module flags
  always_comb begin
    next_ovf_flag = ovf_flag;
    if (wr_ctrl) begin
      next_ovf_flag = i_sfr_wdata[OVF_BIT]; // RULE5
    end
    if (ctr.wrap) begin
      next_ovf_flag = 1'h1; // RULE6
    end
  end

  // overflow flag register
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag <= CTRL_RESET[OVF_BIT]; // RULE6
    end else begin
      ovf_flag <= next_ovf_flag;
    end
  end

  // software run bit; a write under the watchdog skips only this bit, so the
  // bit keeps what software last set and reads that back
  // limitation: software cannot stop the counter until the watchdog is off
  always_comb begin
    next_run_sw = run_sw;
    if (wr_ctrl && !i_watchdog_enable) begin
      next_run_sw = i_sfr_wdata[RUN_BIT]; // RULE7
    end
  end

  // run bit register
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_sw <= CTRL_RESET[RUN_BIT]; // RULE8
    end else begin
      run_sw <= next_run_sw;
    end
  end

  // forced watchdog reset pulse; the module 2 flag write still lands, the
  // pulse is only the extra side effect and lasts one cycle
  // with the watchdog off the same bit is a plain flag write
  always_comb begin
    next_force_rst = 1'h0;
    if (wr_ctrl && i_watchdog_enable) begin
      next_force_rst = i_sfr_wdata[MOD2_BIT]; // RULE9
    end
  end

  // pulse register; the reset logic outside sees a clean one-cycle high
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_rst <= 1'h0;
    end else begin
      force_rst <= next_force_rst;
    end
  end

  // read view shows only the software run bit, never the forced one;
  // the unused middle bits read as zero
  assign ctrl_view = {ovf_flag, run_sw, 3'h0, mod_flag}; // RULE8

  // read data is captured on the read strobe and holds until the next read
  // a read of another address leaves the last captured byte in place
  always_comb begin
    next_rdata = rdata;
    if (rd_ctrl) begin
      next_rdata = ctrl_view;
    end
  end

  // read data register
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= CTRL_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

  // interrupt sources, each gated by its own enable
  assign ovf_request = ovf_flag && i_overflow_int_enable; // RULE6
  assign mod_request = mod_flag & i_module_int_enable; // RULE3

  // level request: it stays up while any enabled flag stays set, so the
  // service routine must clear the flag before it returns
  // no edge detection here: the interrupt logic outside sees a level
  assign o_irq = ovf_request || (|mod_request);

  // outputs straight from the registers and the run gate
  // the count itself is registered inside the counter core
  assign o_counter_running      = ctr.run;
  assign o_count                = ctr.count;
  assign o_sfr_rdata            = rdata;
  assign o_watchdog_force_reset = force_rst;
endmodule : cac_control

// ### bench/cac_control_chk.sv
// port checker for the counter array control block
`timescale 1ns/1ps
module cac_control_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_count_tick,
  input wire logic [2:0]  i_module_event,
  input wire logic [2:0]  i_module_int_enable,
  input wire logic        i_overflow_int_enable,
  input wire logic        i_watchdog_enable,
  input wire logic        o_counter_running,
  input wire logic [15:0] o_count,
  input wire logic        o_irq,
  input wire logic        o_watchdog_force_reset
);
  // inner reset lags release by two edges, so causes wait for three
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_run_watchdog: assert property (i_watchdog_enable |-> o_counter_running)
    else $error("counter stopped under watchdog");
  a_irq_mod: assert property ($past(i_nrst, 3) && i_module_event[0] && i_module_int_enable[0]
    ##1 i_module_int_enable[0] |-> o_irq) else $error("no irq after match");
  a_irq_hold: assert property ($past(i_nrst, 3) && o_irq && !i_sfr_wr ##1
    $stable(i_module_int_enable) && $stable(i_overflow_int_enable) |-> o_irq)
    else $error("flag dropped without write");
  a_force_pulse: assert property ($past(i_nrst, 3) && i_sfr_wr && i_sfr_addr == 8'hD8
    && i_sfr_wdata[2] && i_watchdog_enable |=> o_watchdog_force_reset) else $error("no force");
  a_force_cause: assert property (o_watchdog_force_reset |->
    $past(i_sfr_wr && i_watchdog_enable && i_sfr_wdata[2])) else $error("stray force");
  a_count_hold: assert property (!o_counter_running |=> $stable(o_count))
    else $error("count moved while stopped");
  a_count_step: assert property ($past(i_nrst, 3) && o_counter_running && i_count_tick
    |=> o_count == $past(o_count) + 16'h0001) else $error("count did not step");
  a_ovf_irq: assert property ($past(i_nrst, 3) && o_count == 16'hFFFF && i_count_tick
    && o_counter_running && i_overflow_int_enable ##1 i_overflow_int_enable[*2] |-> o_irq)
    else $error("no irq after wrap");
  c_force: cover property (o_watchdog_force_reset);
  c_irq: cover property (o_irq);
  c_wrap: cover property (o_count == 16'hFFFF);
endmodule : cac_control_chk

// ### bench/counter_array_control_flags_test.sv
// self-checking bench for the counter array control flags
`timescale 1ns/1ps
module counter_array_control_flags_test;
  import cac_pkg::*;
  logic        clk = 0, nrst = 0, wr = 0, rd = 0, tick = 1, oen = 0, wdog = 0;
  logic [7:0]  addr = 8'hD8, wd = 8'h00, rdata;
  logic [2:0]  ev = 3'h0, men = 3'h0;
  logic [15:0] cnt, held;
  logic        run, irq, frc;
  int          fail_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  cac_control i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .i_count_tick(tick),
    .i_module_event(ev), .i_module_int_enable(men), .i_overflow_int_enable(oen),
    .i_watchdog_enable(wdog), .o_counter_running(run), .o_count(cnt), .o_irq(irq),
    .o_watchdog_force_reset(frc));
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // one strobe per access, released at the edge that takes it
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(logic [7:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, CTRL_ADDR};
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 cmp("ctrl", 16'(e), 16'(rdata));
  endtask : rd_reg
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(CTRL_RESET);
    wr_reg(CTRL_ADDR, 8'h40);
    cmp("run", 16'h1, 16'(run));
    rd_reg(8'h40);
    for (int n = 0; n < 3; n++) begin
      @(posedge clk) men <= 3'h1 << n;
      @(posedge clk) ev <= 3'h1 << n;
      @(posedge clk) ev <= 3'h0;
      wr_reg(8'hD0, 8'h00); // unmapped, flag must survive
      cmp("irq", 16'h1, 16'(irq));
      rd_reg(8'h40 | (8'h01 << n));
      wr_reg(CTRL_ADDR, 8'h40);
      cmp("irq", 16'h0, 16'(irq));
    end
    wr_reg(CTRL_ADDR, 8'h00);
    @(posedge clk) wdog <= 1'b1;
    wr_reg(CTRL_ADDR, 8'h40);
    cmp("run", 16'h1, 16'(run));
    rd_reg(8'h00);
    wr_reg(CTRL_ADDR, 8'h04);
    cmp("force", 16'h1, 16'(frc));
    @(posedge clk);
    #1 cmp("force", 16'h0, 16'(frc));
    rd_reg(8'h04);
    @(posedge clk) wdog <= 1'b0;
    wr_reg(CTRL_ADDR, 8'h40);
    @(posedge clk) oen <= 1'b1;
    // no tick, no count, even while running
    @(posedge clk) tick <= 1'b0;
    @(posedge clk) #1 held = cnt;
    repeat (3) @(posedge clk);
    #1 cmp("hold", held, cnt);
    @(posedge clk) tick <= 1'b1;
    // full wrap takes up to 65536 ticks, bounded here
    for (int i = 0; i < 70000 && cnt !== 16'hFFFF; i++) @(posedge clk) #1;
    if (cnt !== 16'hFFFF) begin
      cmp("wrap", 16'hFFFF, cnt);
      end_of_test;
    end
    repeat (3) @(posedge clk);
    #1 cmp("irq", 16'h1, 16'(irq));
    repeat (20) @(posedge clk);
    rd_reg(8'hC0);
    wr_reg(CTRL_ADDR, 8'h40);
    cmp("irq", 16'h0, 16'(irq));
    end_of_test;
  end
endmodule : counter_array_control_flags_test
bind cac_control cac_control_chk i_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
  .i_count_tick(i_count_tick), .i_module_event(i_module_event),
  .i_module_int_enable(i_module_int_enable), .i_overflow_int_enable(i_overflow_int_enable),
  .i_watchdog_enable(i_watchdog_enable), .o_counter_running(o_counter_running),
  .o_count(o_count), .o_irq(o_irq), .o_watchdog_force_reset(o_watchdog_force_reset));
